//--- hw/udd_chain.sv
// Ultrasound Doppler receive chain: strobe divider, I/Q, magnitude, filters, threshold sign
// Overview of operation
// (RQ1) Fractional-N divider makes 160 kHz strobe
// (RQ2) Strobe split into four phases, shared tx
// (RQ3) One converter sample taken per strobe
// (RQ4) In-phase is third minus first sample
// (RQ5) Quadrature is fourth minus second sample
// (RQ6) CORDIC gives root of I2 plus Q2
// (RQ7) Single-pole low-pass, bandwidth by control bit
// (RQ8) Accumulate-and-dump decimation by eighteen
// (RQ9) One or two high-pass poles, bit four
// (RQ10) Pole bits [3:2] first, [1:0] second
// (RQ11) Programmed threshold subtracted after high-pass
// (RQ12) Sixteen log threshold steps, 0.1-9.4 percent
// (RQ13) Only the sign goes downstream
// (RQ14) Transmit wave is divided 40 kHz tone
// (RQ15) I and Q values made available
// (RQ16) Final receive amplifier gain digitally set
// (RQ17) Detects 0.9 percent modulation at best
// (RQ18) Low-pass select 0 is 100 Hz, 1 is 200 Hz
// (RQ19) Digital reset clears all filter state
// (RQ20) Decimator reloads with sample on dump
// (RQ21) Threshold code mapped through fixed table
//
// Strobed register access and the register offsets were decided locally.
module udd_chain (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire udd_pkg::udd_reg_req_t i_reg,
	input wire logic [7:0] i_adc_data,
	output logic [15:0] o_reg_rdata,
	output logic o_adc_strobe,
	output logic o_tx_wave,
	output logic [3:0] o_rx_gain,
	output udd_pkg::udd_demod_t o_demod,
	output logic o_detect_negative,
	output logic o_detect_valid
);
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [11:0] div_cnt;
		logic [7:0] frac_acc;
		logic long_period;
		logic strobe;
		logic [1:0] phase;
		logic [2:0][7:0] smp;
		logic start;
		udd_pkg::udd_demod_t demod;
		logic [17:0] lpf;
		logic [14:0] dec_acc;
		logic [4:0] dec_cnt;
		logic signed [23:0] hp1;
		logic signed [23:0] hp2;
		logic signed [15:0] hp_out;
		logic negative;
		logic valid;
		logic tx;
		logic [11:0] div_int;
		logic [7:0] div_frac;
		logic [5:0] filt;
		logic [3:0] thres;
		logic [3:0] gain;
		logic [15:0] rdata;
	} udd_state_t;

	udd_state_t st_ff;
	udd_state_t nxt_st;
	logic fire;
	logic [8:0] frac_sum;
	logic [11:0] limit;
	logic cordic_done;
	logic [9:0] cordic_mag;
	logic signed [18:0] lpf_diff;
	logic [9:0] lpf_int;
	logic dump;
	logic signed [23:0] hp_in;
	logic signed [23:0] d1;
	logic signed [23:0] d2;
	logic signed [23:0] hp_y;
	logic signed [16:0] thr_diff;

	// Magnitude engine, started once per complete four-sample group
	udd_cordic u_cordic (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_start(st_ff.start),
		.i_i(st_ff.demod.i),
		.i_q(st_ff.demod.q),
		.o_done(cordic_done),
		.o_mag(cordic_mag)
	);

	// Whole chain as one next-state computation
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.strobe = 1'b0;
		nxt_st.start = 1'b0;
		nxt_st.valid = 1'b0;
		nxt_st.rdata = 16'h0000;
		lpf_diff = '0;
		lpf_int = st_ff.lpf[17:8];
		dump = 1'b0;
		hp_in = '0;
		d1 = '0;
		d2 = '0;
		hp_y = '0;
		thr_diff = '0;

		// Converter bus comes from another domain, two stages before use
		nxt_st.sync1 = i_adc_data;
		nxt_st.sync2 = st_ff.sync1;

		// Period alternates N and N+1 so the average is N + F/256
		frac_sum = {1'b0, st_ff.frac_acc} + {1'b0, st_ff.div_frac};
		limit = st_ff.long_period ? st_ff.div_int : st_ff.div_int - 12'h001;
		fire = (st_ff.div_cnt >= limit); // RQ1
		if (fire)
		begin
			nxt_st.div_cnt = 12'h000;
			nxt_st.frac_acc = frac_sum[7:0]; // RQ1
			nxt_st.long_period = frac_sum[8];
			nxt_st.strobe = 1'b1;
			nxt_st.phase = st_ff.phase + 2'h1; // RQ2
			// Tone follows phase so receive demodulation stays homodyne
			nxt_st.tx = nxt_st.phase[1]; // RQ14
			if (st_ff.phase == 2'h3)
			begin
				nxt_st.demod.i = 9'({1'b0, st_ff.smp[2]}) - 9'({1'b0, st_ff.smp[0]}); // RQ4
				nxt_st.demod.q = 9'({1'b0, st_ff.sync2}) - 9'({1'b0, st_ff.smp[1]}); // RQ5
				nxt_st.start = 1'b1; // RQ6
			end
			else
				nxt_st.smp[st_ff.phase] = st_ff.sync2; // RQ3
		end
		else
			nxt_st.div_cnt = st_ff.div_cnt + 12'h001;

		// Low-pass at 40 kS/s, shift 6 near 100 Hz and 5 near 200 Hz
		if (cordic_done)
		begin
			nxt_st.demod.mag = cordic_mag; // RQ15
			lpf_diff = 19'({cordic_mag, 8'h00}) - 19'(st_ff.lpf);
			if (st_ff.filt[udd_pkg::FILT_LPF_BIT]) // RQ18
				nxt_st.lpf = 18'($signed(19'(st_ff.lpf)) + (lpf_diff >>> udd_pkg::LPF_SHIFT_200)); // RQ7
			else
				nxt_st.lpf = 18'($signed(19'(st_ff.lpf)) + (lpf_diff >>> udd_pkg::LPF_SHIFT_100)); // RQ7
			lpf_int = nxt_st.lpf[17:8];
			// Dump the full sum, restart from this sample
			if (st_ff.dec_cnt == udd_pkg::DECIM)
			begin
				dump = 1'b1; // RQ8
				nxt_st.dec_acc = 15'(lpf_int); // RQ20
				nxt_st.dec_cnt = 5'h01;
			end
			else
			begin
				nxt_st.dec_acc = st_ff.dec_acc + 15'(lpf_int); // RQ8
				nxt_st.dec_cnt = st_ff.dec_cnt + 5'h01;
			end
		end

		// High-pass poles at 2.22 kS/s, each pole is input minus its tracking low-pass
		if (dump)
		begin
			hp_in = 24'({st_ff.dec_acc, 8'h00});
			d1 = hp_in - st_ff.hp1;
			nxt_st.hp1 = st_ff.hp1 + udd_pkg::udd_hp_coef(d1, st_ff.filt[3:2]); // RQ10
			hp_y = d1;
			if (st_ff.filt[udd_pkg::FILT_TWO_POLE_BIT]) // RQ9
			begin
				d2 = d1 - st_ff.hp2;
				nxt_st.hp2 = st_ff.hp2 + udd_pkg::udd_hp_coef(d2, st_ff.filt[1:0]); // RQ10
				hp_y = d2;
			end
			nxt_st.hp_out = hp_y[23:8];
			// Table step 5 is the most sensitive useful setting
			// Sign-extend the filtered value, a falling signal must stay negative
			thr_diff = 17'($signed(hp_y[23:8])) - 17'(udd_pkg::udd_thr_value(st_ff.thres)); // RQ11 RQ12 RQ17 RQ21
			nxt_st.negative = thr_diff[16]; // RQ13
			nxt_st.valid = 1'b1;
		end

		// Register writes; divider needs at least a few cycles per strobe
		if (i_reg.wr)
		begin
			case (i_reg.addr)
				udd_pkg::A_DIV_INT: nxt_st.div_int = i_reg.wdata[11:0]; // RQ1
				udd_pkg::A_DIV_FRAC: nxt_st.div_frac = i_reg.wdata[7:0]; // RQ1
				udd_pkg::A_FILT: nxt_st.filt = i_reg.wdata[5:0];
				udd_pkg::A_THRES: nxt_st.thres = i_reg.wdata[3:0];
				udd_pkg::A_GAIN: nxt_st.gain = i_reg.wdata[3:0]; // RQ16
				default: nxt_st.div_int = st_ff.div_int;
			endcase
		end

		// Read data lands one cycle after the strobe, unmapped reads zero
		if (i_reg.rd)
		begin
			case (i_reg.addr)
				udd_pkg::A_DIV_INT: nxt_st.rdata = {4'h0, st_ff.div_int};
				udd_pkg::A_DIV_FRAC: nxt_st.rdata = {8'h00, st_ff.div_frac};
				udd_pkg::A_FILT: nxt_st.rdata = {10'h000, st_ff.filt};
				udd_pkg::A_THRES: nxt_st.rdata = {12'h000, st_ff.thres};
				udd_pkg::A_GAIN: nxt_st.rdata = {12'h000, st_ff.gain};
				udd_pkg::A_I: nxt_st.rdata = 16'(st_ff.demod.i); // RQ15
				udd_pkg::A_Q: nxt_st.rdata = 16'(st_ff.demod.q); // RQ15
				udd_pkg::A_MAG: nxt_st.rdata = {6'h00, st_ff.demod.mag};
				udd_pkg::A_HP: nxt_st.rdata = st_ff.hp_out;
				udd_pkg::A_SIGN: nxt_st.rdata = {15'h0000, st_ff.negative};
				default: nxt_st.rdata = 16'h0000;
			endcase
		end
	end

	// Reset clears every filter and sample; configuration back to defaults
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			st_ff <= '0; // RQ19
			st_ff.div_int <= udd_pkg::DIV_INT_RST;
			st_ff.div_frac <= udd_pkg::DIV_FRAC_RST;
			st_ff.filt <= udd_pkg::FILT_RST;
			st_ff.thres <= udd_pkg::THRES_RST;
			st_ff.gain <= udd_pkg::GAIN_RST;
		end
		else
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register
	assign o_reg_rdata = st_ff.rdata;
	assign o_adc_strobe = st_ff.strobe;
	assign o_tx_wave = st_ff.tx;
	assign o_rx_gain = st_ff.gain;
	assign o_demod = st_ff.demod;
	assign o_detect_negative = st_ff.negative;
	assign o_detect_valid = st_ff.valid;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	a_strobe_gap: assert property ( // RQ1
		o_adc_strobe && st_ff.div_int > 12'h008 |=> !o_adc_strobe [*8])
		else $error("strobe repeated too soon");
	a_strobe_count: assert property ( // RQ1
		fire |-> st_ff.div_cnt == st_ff.div_int - 12'h001 || st_ff.div_cnt == st_ff.div_int || $past(i_reg.wr))
		else $error("strobe period not N or N+1");
	a_phase_step: assert property ( // RQ2
		fire |=> st_ff.phase == $past(st_ff.phase) + 2'h1 && o_adc_strobe)
		else $error("phase did not advance on strobe");
	a_tone_phase: assert property ( // RQ14
		o_adc_strobe |-> o_tx_wave == st_ff.phase[1])
		else $error("transmit tone out of step with phase");
	a_iq_pair: assert property ( // RQ4
		fire && st_ff.phase == 2'h3 |=> st_ff.start
			&& o_demod.i == 9'({1'b0, $past(st_ff.smp[2])}) - 9'({1'b0, $past(st_ff.smp[0])}))
		else $error("in-phase value wrong");
	a_quad_pair: assert property ( // RQ5
		fire && st_ff.phase == 2'h3 |=> o_demod.q == 9'({1'b0, $past(st_ff.sync2)}) - 9'({1'b0, $past(st_ff.smp[1])}))
		else $error("quadrature value wrong");
	a_lpf_track: assert property ( // RQ7
		cordic_done && {cordic_mag, 8'h00} > st_ff.lpf |=> st_ff.lpf >= $past(st_ff.lpf))
		else $error("low-pass moved away from input");
	a_decim_reload: assert property ( // RQ20
		dump |=> st_ff.dec_cnt == 5'h01 && st_ff.dec_acc == 15'($past(lpf_int)) && o_detect_valid)
		else $error("decimator did not reload on dump");
	a_sign_only: assert property ( // RQ13
		o_detect_valid |-> o_detect_negative == ($signed(17'(st_ff.hp_out))
			< $signed(17'(udd_pkg::udd_thr_value(st_ff.thres)))))
		else $error("sign does not match threshold difference");
	a_reset_clear: assert property ( // RQ19
		$rose(i_rst_n) |-> st_ff.lpf == 18'h0 && st_ff.hp1 == 0 && st_ff.hp2 == 0 && st_ff.dec_acc == 15'h0)
		else $error("filter state not cleared by reset");
endmodule : udd_chain

//--- hw/udd_cordic.sv
// Iterative vectoring CORDIC giving the magnitude of an I/Q pair
module udd_cordic (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic signed [8:0] i_i,
	input wire logic signed [8:0] i_q,
	output logic o_done,
	output logic [9:0] o_mag
);
	typedef struct packed {
		logic signed [11:0] x;
		logic signed [11:0] y;
		logic [3:0] k;
		logic busy;
		logic done;
		logic [9:0] mag;
	} udd_cordic_st_t;

	udd_cordic_st_t st_ff;
	udd_cordic_st_t nxt_st;
	logic signed [11:0] x_gain;

	// One rotation per cycle, eight cycles well inside one 40 kHz group
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		x_gain = '0;
		if (i_start)
		begin
			nxt_st.x = (i_i < 0) ? -12'(i_i) : 12'(i_i);
			nxt_st.y = 12'(i_q);
			nxt_st.k = 4'h0;
			nxt_st.busy = 1'b1;
		end
		else if (st_ff.busy)
		begin
			if (st_ff.y >= 0)
			begin
				nxt_st.x = st_ff.x + (st_ff.y >>> st_ff.k);
				nxt_st.y = st_ff.y - (st_ff.x >>> st_ff.k);
			end
			else
			begin
				nxt_st.x = st_ff.x - (st_ff.y >>> st_ff.k);
				nxt_st.y = st_ff.y + (st_ff.x >>> st_ff.k);
			end
			nxt_st.k = st_ff.k + 4'h1;
			if (st_ff.k == udd_pkg::CORDIC_LAST)
			begin
				// Gain 1/1.647 folded in as shifts, trades 0.3% error for no multiplier
				x_gain = (nxt_st.x >>> 1) + (nxt_st.x >>> 3) - (nxt_st.x >>> 6);
				nxt_st.mag = x_gain[9:0];
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end
		end
	end

	// State register with synchronous reset
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign o_done = st_ff.done;
	assign o_mag = st_ff.mag;

	a_cordic_latency: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ6
		i_start |-> ##9 o_done)
		else $error("magnitude not ready nine cycles after start");
	a_cordic_bound: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ6
		i_start ##9 o_done |-> (o_mag + 10'h8 >= $past(st_ff.x, 8) - 12'h0) || $past(i_q, 9) != 0)
		else $error("magnitude of a pure in-phase pair too small");
endmodule : udd_cordic

//--- hw/udd_pkg.sv
// Package: constants, register map and carrier types of the Doppler demodulation chain
package udd_pkg;
	// Timing: core clock and sampling strobe rate
	localparam int CLK_HZ = 200_000_000;
	localparam int STROBE_HZ = 160_000;
	localparam logic [11:0] DIV_INT_RST = 12'(CLK_HZ / STROBE_HZ);
	localparam logic [7:0] DIV_FRAC_RST = 8'h00;
	localparam logic [5:0] FILT_RST = 6'h35;
	localparam logic [3:0] THRES_RST = 4'h8;
	localparam logic [3:0] GAIN_RST = 4'h8;
	localparam logic [4:0] DECIM = 5'h12;
	localparam logic [3:0] CORDIC_LAST = 4'h7;
	localparam int LPF_SHIFT_100 = 6;
	localparam int LPF_SHIFT_200 = 5;
	localparam int FRAC_W = 8;

	// Register map, word index on the plain register port
	localparam logic [3:0] A_DIV_INT = 4'h0;
	localparam logic [3:0] A_DIV_FRAC = 4'h1;
	localparam logic [3:0] A_FILT = 4'h2;
	localparam logic [3:0] A_THRES = 4'h3;
	localparam logic [3:0] A_GAIN = 4'h4;
	localparam logic [3:0] A_I = 4'h5;
	localparam logic [3:0] A_Q = 4'h6;
	localparam logic [3:0] A_MAG = 4'h7;
	localparam logic [3:0] A_HP = 4'h8;
	localparam logic [3:0] A_SIGN = 4'h9;
	localparam int FILT_LPF_BIT = 5;
	localparam int FILT_TWO_POLE_BIT = 4;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} udd_reg_req_t;

	// Demodulated I, Q and amplitude
	typedef struct packed {
		logic signed [8:0] i;
		logic signed [8:0] q;
		logic [9:0] mag;
	} udd_demod_t;

	// Threshold code to decimated-stream units, full scale taken as 18*256
	function automatic logic [15:0] udd_thr_value(input logic [3:0] code);
		case (code)
			4'h0: udd_thr_value = 16'h0005;
			4'h1: udd_thr_value = 16'h0007;
			4'h2: udd_thr_value = 16'h0009;
			4'h3: udd_thr_value = 16'h000b;
			4'h4: udd_thr_value = 16'h000e;
			4'h5: udd_thr_value = 16'h0010;
			4'h6: udd_thr_value = 16'h0012;
			4'h7: udd_thr_value = 16'h001b;
			4'h8: udd_thr_value = 16'h0024;
			4'h9: udd_thr_value = 16'h0037;
			4'ha: udd_thr_value = 16'h004a;
			4'hb: udd_thr_value = 16'h006a;
			4'hc: udd_thr_value = 16'h008f;
			4'hd: udd_thr_value = 16'h00d9;
			4'he: udd_thr_value = 16'h0122;
			default: udd_thr_value = 16'h01b1;
		endcase
	endfunction : udd_thr_value

	// High-pass pole coefficient as shift sums, about 11.5/14.8/17.8/21.3 Hz at 2.22 kS/s
	function automatic logic signed [23:0] udd_hp_coef(input logic signed [23:0] x, input logic [1:0] sel);
		case (sel)
			2'h0: udd_hp_coef = x >>> 5;
			2'h1: udd_hp_coef = (x >>> 5) + (x >>> 7);
			2'h2: udd_hp_coef = (x >>> 5) + (x >>> 6) + (x >>> 8);
			default: udd_hp_coef = x >>> 4;
		endcase
	endfunction : udd_hp_coef
endpackage : udd_pkg

//--- test/udd_chain_test.sv
// Self-checking bench of the Doppler demodulation chain
module udd_chain_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic wr;
		logic [3:0] a;
		logic [15:0] d;
		logic [15:0] e;
	} udd_row_t;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	udd_pkg::udd_reg_req_t i_reg = '0;
	logic [7:0] adc;
	logic [15:0] rdata;
	logic strobe, tx, neg, valid;
	logic [3:0] gain;
	udd_pkg::udd_demod_t demod;
	logic [3:0][7:0] samples = {8'h3c, 8'h6e, 8'h14, 8'h0a};
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int vcount, c, sum, v0;
	logic [15:0] got;
	logic txs [10];
	// Reset values, field widths, read-only and unmapped places
	udd_row_t rows [18] = '{
		'{1'b0, 4'h0, 16'h0, 16'h04e2}, '{1'b0, 4'h1, 16'h0, 16'h0000}, '{1'b0, 4'h2, 16'h0, 16'h0035},
		'{1'b0, 4'h3, 16'h0, 16'h0008}, '{1'b0, 4'h4, 16'h0, 16'h0008}, '{1'b0, 4'ha, 16'h0, 16'h0000},
		'{1'b0, 4'hf, 16'h0, 16'h0000}, '{1'b1, 4'h4, 16'hfff3, 16'h0}, '{1'b0, 4'h4, 16'h0, 16'h0003},
		'{1'b1, 4'h5, 16'h1234, 16'h0}, '{1'b0, 4'h5, 16'h0, 16'h0000}, '{1'b1, 4'h2, 16'hffff, 16'h0},
		'{1'b0, 4'h2, 16'h0, 16'h003f}, '{1'b1, 4'h3, 16'hffff, 16'h0}, '{1'b0, 4'h3, 16'h0, 16'h000f},
		'{1'b1, 4'h2, 16'h002c, 16'h0}, '{1'b1, 4'h0, 16'h0010, 16'h0}, '{1'b1, 4'h1, 16'h0080, 16'h0}};

	always #2.5 i_clock = ~i_clock;

	udd_chain i_udd_chain (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg(i_reg), .i_adc_data(adc),
		.o_reg_rdata(rdata), .o_adc_strobe(strobe), .o_tx_wave(tx), .o_rx_gain(gain), .o_demod(demod),
		.o_detect_negative(neg), .o_detect_valid(valid));
	udd_sensor_model i_udd_sensor_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_strobe(strobe),
		.i_samples(samples), .i_valid(valid), .o_adc_data(adc), .o_valid_count(vcount));

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic chk_cnt(input int g, input int e);
		chk(16'(g), 16'(e));
	endtask : chk_cnt

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_reg <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		i_reg.wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clock);
		i_reg <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		i_reg.rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd

	// Cycles until a one-cycle pulse is seen; no timeout here, the hang guard ends a wait on a dead pulse
	task automatic wait_hi(ref logic s, output int n);
		n = 0;
		do
		begin
			@(posedge i_clock);
			#1 n++;
		end
		while (s !== 1'b1);
	endtask : wait_hi

	task automatic chk_idle(input logic [3:0] g);
		chk({12'h0, gain}, {12'h0, g});
		chk({13'h0, tx, neg, valid}, 16'h0);
		chk(demod[15:0], 16'h0);
		chk({4'h0, demod[27:16]}, 16'h0);
	endtask : chk_idle

	task automatic final_report();
		$display("checked=%0d bad=%0d valids=%0d", samples_checked, bad_count, vcount);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// Hang guard, about 1.7 times the expected run
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			bad_count++;
			final_report();
		end
	end

	initial
	begin
		repeat (20) @(posedge i_clock);
		#1 chk_idle(4'h8);
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		foreach (rows[k])
		begin
			if (rows[k].wr)
				reg_wr(rows[k].a, rows[k].d);
			else
			begin
				reg_rd(rows[k].a, got);
				chk(got, rows[k].e);
			end
		end
		chk({12'h0, gain}, 16'h0003);
		// Fraction one half: any four periods hold exactly two long ones
		repeat (3) wait_hi(strobe, c);
		sum = 0;
		for (int k = 0; k < 4; k++)
		begin
			wait_hi(strobe, c);
			sum += c;
		end
		chk_cnt(sum, 66);
		reg_wr(4'h1, 16'h0000);
		repeat (2) wait_hi(strobe, c);
		wait_hi(strobe, c);
		chk_cnt(c, 16);
		// Transmit level flips every second strobe: four strobes per tone period
		foreach (txs[k])
		begin
			wait_hi(strobe, c);
			txs[k] = tx;
		end
		for (int k = 0; k < 8; k++)
			chk({15'h0, txs[k] ^ txs[k + 2]}, 16'h0001);
		// Samples 10, 20, 110, 60 give I 100 and Q 40, amplitude near 108
		repeat (12) wait_hi(strobe, c);
		chk({7'h0, demod.i}, 16'h0064);
		reg_rd(udd_pkg::A_Q, got);
		chk(got, 16'h0028);
		reg_rd(udd_pkg::A_MAG, got);
		chk({15'h0, got >= 16'h0068 && got <= 16'h0070}, 16'h0001);
		@(posedge i_clock);
		samples[0] <= 8'h6e;
		samples[2] <= 8'h0a;
		repeat (12) wait_hi(strobe, c);
		reg_rd(udd_pkg::A_I, got);
		chk(got, 16'hff9c);
		// Decimated stream: 18 groups of 4 strobes of 16 cycles
		wait_hi(valid, c);
		wait_hi(valid, c);
		chk_cnt(c, 1152);
		@(posedge i_clock);
		#1 chk({15'h0, valid}, 16'h0);
		// Steady amplitude decays out of the high-pass, largest threshold wins
		v0 = vcount;
		repeat (45) wait_hi(valid, c);
		chk({15'h0, neg}, 16'h0001);
		// Detector counts the last pulse one edge later
		chk_cnt(vcount - v0, 44);
		reg_rd(udd_pkg::A_SIGN, got);
		chk(got, 16'h0001);
		// Second reset in mid-run clears filters and restores registers
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		#1 chk_idle(4'h8);
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		reg_rd(udd_pkg::A_HP, got);
		chk(got, 16'h0000);
		reg_rd(udd_pkg::A_FILT, got);
		chk(got, 16'h0035);
		final_report();
	end
endmodule : udd_chain_test

//--- test/udd_sensor_model.sv
// Far-side model: converter feeding samples by phase, detector counting sign updates
module udd_sensor_model (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_strobe,
	input wire logic [3:0][7:0] i_samples,
	input wire logic i_valid,
	output logic [7:0] o_adc_data,
	output int o_valid_count
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] phase_ff;

	// Phase follows the chain's strobe, so data is settled long before the next fire
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			phase_ff <= 2'h0;
		else if (i_strobe)
			phase_ff <= phase_ff + 2'h1;
	end

	assign o_adc_data = i_samples[phase_ff];

	// Detector side only counts sign updates
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_valid_count <= 0;
		else if (i_valid)
			o_valid_count <= o_valid_count + 1;
	end
endmodule : udd_sensor_model
